// >>> verilog/cmp_ctrl_consts.vh
/*
 Constants for the analog comparator control block: register map, bit
 positions, reset values and interrupt mode codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CMP_CTRL_CONSTS_VH
`define CMP_CTRL_CONSTS_VH

`define ADDR_W            2
`define OFS_CSR           2'h0
`define OFS_IRQ_STATUS    2'h1
`define OFS_IRQ_MASK      2'h2

`define BIT_POWER_OFF     7
`define BIT_BANDGAP       6
`define BIT_RESULT        5
`define BIT_FLAG          4
`define BIT_IRQ_EN        3
`define BIT_NEGMUX_EN     2
`define BIT_MODE_HI       1
`define BIT_MODE_LO       0

`define CSR_RESET         8'h00
`define MASK_RESET        8'h00
`define MODE_TOGGLE       2'h0
`define MODE_RESERVED     2'h1
`define MODE_FALL         2'h2
`define MODE_RISE         2'h3

`define CHAN_LAST         4'hA
`define NEG_PIN_CODE      4'hF
`define EVT_W             2
`define EVT_EDGE          0
`define EVT_TOP_CHANGE    1

`endif

// >>> verilog/cmp_sync.v
/*
 Two flip-flop level synchroniser.
 Assumes an asynchronous source and the comparator clock domain.
*/
`timescale 1ns/10ps
module cmp_sync (
	input  wire core_clk,
	input  wire rst_n,
	input  wire async_in,
	output reg  sync_out
);
	reg stage1;

	// First stage feeds only the second
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// >>> verilog/cmp_ctrl.v
/*
 Analog comparator control: control and status register, input selection,
 edge interrupt flag, plus a sticky event status and mask over Avalon-MM.
 Assumes the analog comparator result arrives asynchronously on cmp_out_async
 and that converter enable, channel select and global enable are
 synchronous to core_clk.
*/
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "cmp_ctrl_consts.vh"
module cmp_ctrl (
	input  wire                core_clk,
	input  wire                rst_n,
	input  wire                clk_en,
	input  wire [`ADDR_W-1:0]  avs_address,
	input  wire                avs_read,
	input  wire                avs_write,
	input  wire [31:0]         avs_writedata,
	input  wire [3:0]          avs_byteenable,
	output reg  [31:0]         avs_readdata,
	output reg                 avs_waitrequest,
	output reg                 avs_response_err,
	input  wire                cmp_out_async,
	input  wire                conv_enable,
	input  wire [3:0]          chan_sel_low,
	input  wire                chan_sel_top,
	input  wire                global_irq_en,
	input  wire                vector_ack,
	output reg                 cmp_irq_req,
	output reg                 cmp_power_off_out,
	output reg                 cmp_bandgap_sel_out,
	output reg                 neg_use_mux,
	output reg  [3:0]          neg_chan,
	output reg                 neg_chan_valid,
	output reg                 pin_change_block,
	output reg                 irq
);
	reg                cmp_power_off;
	reg                cmp_bandgap_sel;
	reg                cmp_irq_flag;
	reg                cmp_irq_en;
	reg                cmp_negmux_en;
	reg                cmp_irq_mode_hi;
	reg                cmp_irq_mode_lo;
	reg                cmp_result_prev;
	reg  [3:0]         chan_sel_d;
	reg                chan_top_d;
	reg  [`EVT_W-1:0]  evt_status;
	reg  [`EVT_W-1:0]  evt_mask;
	reg                ack_pending;
	wire               cmp_result;
	wire               rise;
	wire               fall;
	reg                edge_hit;
	wire [1:0]         mode;
	wire               csr_wr;
	wire               sts_wr;
	wire               msk_wr;
	wire [7:0]         csr_view;
	wire [`EVT_W-1:0]  evt_set;
	wire [`EVT_W-1:0]  next_evt_status;
	reg  [31:0]        next_readdata;
	reg                next_err;
	wire               access;
	wire               wr_commit;

	// Asynchronous comparator output must be settled before edge logic
	cmp_sync u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (cmp_out_async),
		.sync_out (cmp_result)
	);

	assign mode = {cmp_irq_mode_hi, cmp_irq_mode_lo};
	assign rise = cmp_result & ~cmp_result_prev;
	assign fall = ~cmp_result & cmp_result_prev;

	// Reserved mode never fires; keeps a stray setting harmless
	always @* begin
		case (mode)
			`MODE_TOGGLE: edge_hit = rise | fall;
			`MODE_FALL:   edge_hit = fall;
			`MODE_RISE:   edge_hit = rise;
			default:      edge_hit = 1'b0;
		endcase
	end

	// Single-cycle accepted access: waitrequest drops two cycles after request
	assign access = (avs_read | avs_write) & avs_waitrequest & clk_en & ack_pending;
	// Writes land only at the edge where the master sees waitrequest low
	assign wr_commit = avs_write & ~avs_waitrequest & clk_en & avs_byteenable[0];
	assign csr_wr = wr_commit & (avs_address == `OFS_CSR);
	assign sts_wr = wr_commit & (avs_address == `OFS_IRQ_STATUS);
	assign msk_wr = wr_commit & (avs_address == `OFS_IRQ_MASK);

	// Result bit is the live synchronised comparator value, not stored
	assign csr_view = {cmp_power_off, cmp_bandgap_sel, cmp_result, cmp_irq_flag,
		cmp_irq_en, cmp_negmux_en, cmp_irq_mode_hi, cmp_irq_mode_lo};

	assign evt_set = {(chan_sel_d != chan_sel_low) | (chan_top_d != chan_sel_top),
		edge_hit & ~cmp_power_off};
	// Set wins over write-one-to-clear
	assign next_evt_status = evt_set |
		(evt_status & ~(sts_wr ? avs_writedata[`EVT_W-1:0] : {`EVT_W{1'b0}}));

	always @* begin
		next_readdata = 32'h0000_0000;
		next_err      = 1'b0;
		case (avs_address)
			`OFS_CSR:        next_readdata[7:0] = csr_view;
			`OFS_IRQ_STATUS: next_readdata[`EVT_W-1:0] = evt_status;
			`OFS_IRQ_MASK:   next_readdata[`EVT_W-1:0] = evt_mask;
			default:         next_err = 1'b1;
		endcase
	end

	// Bus handshake: two wait cycles, then data and waitrequest low together
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			if (access) begin
				avs_waitrequest <= 1'b0;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// Arms on the first requested edge, so every answer takes two edges
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_pending <= 1'b0;
		end else if (clk_en) begin
			if (access) begin
				ack_pending <= 1'b0;
			end else begin
				ack_pending <= (avs_read | avs_write) & avs_waitrequest;
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (access) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_response_err <= 1'b0;
		end else if (clk_en) begin
			if (access) begin
				avs_response_err <= next_err;
			end else begin
				avs_response_err <= 1'b0;
			end
		end
	end

	// Software may power down at any time
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_power_off <= 1'b0;
		end else if (clk_en) begin
			if (csr_wr) begin
				cmp_power_off <= avs_writedata[`BIT_POWER_OFF];
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_bandgap_sel <= 1'b0;
		end else if (clk_en) begin
			if (csr_wr) begin
				cmp_bandgap_sel <= avs_writedata[`BIT_BANDGAP];
			end
		end
	end

	// Edge set wins over both clears
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_irq_flag <= 1'b0;
		end else if (clk_en) begin
			if (edge_hit & ~cmp_power_off) begin
				cmp_irq_flag <= 1'b1;
			end else if (vector_ack | (csr_wr & avs_writedata[`BIT_FLAG])) begin
				cmp_irq_flag <= 1'b0;
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_irq_en <= 1'b0;
		end else if (clk_en) begin
			if (csr_wr) begin
				cmp_irq_en <= avs_writedata[`BIT_IRQ_EN];
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_negmux_en <= 1'b0;
		end else if (clk_en) begin
			if (csr_wr) begin
				cmp_negmux_en <= avs_writedata[`BIT_NEGMUX_EN];
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_irq_mode_hi <= 1'b0;
		end else if (clk_en) begin
			if (csr_wr) begin
				cmp_irq_mode_hi <= avs_writedata[`BIT_MODE_HI];
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_irq_mode_lo <= 1'b0;
		end else if (clk_en) begin
			if (csr_wr) begin
				cmp_irq_mode_lo <= avs_writedata[`BIT_MODE_LO];
			end
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_result_prev <= 1'b0;
		end else if (clk_en) begin
			cmp_result_prev <= cmp_result;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_sel_d <= 4'h0;
		end else if (clk_en) begin
			chan_sel_d <= chan_sel_low;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_top_d <= 1'b0;
		end else if (clk_en) begin
			chan_top_d <= chan_sel_top;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_status <= {`EVT_W{1'b0}};
		end else if (clk_en) begin
			evt_status <= next_evt_status;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_mask <= {`EVT_W{1'b0}};
		end else if (clk_en) begin
			if (msk_wr) begin
				evt_mask <= avs_writedata[`EVT_W-1:0];
			end
		end
	end

	// Registered outputs; selection follows the delayed channel code
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_irq_req <= 1'b0;
		end else if (clk_en) begin
			cmp_irq_req <= cmp_irq_flag & cmp_irq_en & global_irq_en;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_power_off_out <= 1'b0;
		end else if (clk_en) begin
			cmp_power_off_out <= cmp_power_off;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_bandgap_sel_out <= 1'b0;
		end else if (clk_en) begin
			cmp_bandgap_sel_out <= cmp_bandgap_sel;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			neg_use_mux <= 1'b0;
		end else if (clk_en) begin
			neg_use_mux <= cmp_negmux_en & ~conv_enable;
		end
	end

	// Top channel bit deliberately unused here
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			neg_chan <= `NEG_PIN_CODE;
		end else if (clk_en) begin
			neg_chan <= (cmp_negmux_en & ~conv_enable) ? chan_sel_d
				: `NEG_PIN_CODE;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			neg_chan_valid <= 1'b0;
		end else if (clk_en) begin
			neg_chan_valid <= cmp_negmux_en & ~conv_enable &
				(chan_sel_d <= `CHAN_LAST);
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_change_block <= 1'b0;
		end else if (clk_en) begin
			pin_change_block <= ~cmp_power_off;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(next_evt_status & evt_mask);
		end
	end
endmodule

// >>> dv/cmp_ctrl_assertions.sv
/*
 Checker for cmp_ctrl: bus timing, power, pin-change block, input select.
 Assumes clk_en held high, so no cycle is frozen.
*/
`timescale 1ns/10ps
module cmp_ctrl_chk (
	input wire        core_clk,
	input wire        rst_n,
	input wire [1:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire        avs_waitrequest,
	input wire [3:0]  chan_sel_low,
	input wire        global_irq_en,
	input wire        cmp_irq_req,
	input wire        cmp_power_off_out,
	input wire        cmp_bandgap_sel_out,
	input wire        neg_use_mux,
	input wire [3:0]  neg_chan,
	input wire        neg_chan_valid,
	input wire        pin_change_block
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence csr_wr;
		avs_write && !avs_waitrequest && avs_address == 2'h0 && avs_byteenable[0];
	endsequence
	sequence powered_3;
		!cmp_power_off_out [*3];
	endsequence
	sequence two_edge_answer;
		avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	chk_power_wr: assert property (csr_wr |-> ##2
		cmp_power_off_out == $past(avs_writedata[7], 2))
		else $error("power off bit not taken from write");
	chk_bandgap_wr: assert property (csr_wr |-> ##2
		cmp_bandgap_sel_out == $past(avs_writedata[6], 2))
		else $error("bandgap select not taken from write");
	chk_block_on: assert property (powered_3 |-> pin_change_block)
		else $error("pin change not blocked while powered");
	chk_block_off: assert property (cmp_power_off_out [*2] |-> !pin_change_block)
		else $error("pin change blocked while powered off");
	chk_pin_fallback: assert property (!neg_use_mux |-> neg_chan == 4'hF)
		else $error("negative pin code wrong");
	chk_chan_delay: assert property (neg_use_mux |-> neg_chan == $past(chan_sel_low, 2))
		else $error("channel select delay wrong");
	chk_chan_valid: assert property (neg_chan_valid == (neg_use_mux && neg_chan <= 4'hA))
		else $error("channel valid wrong");
	chk_req_global: assert property (cmp_irq_req |-> $past(global_irq_en))
		else $error("request without global enable");
	chk_bus_answer: assert property ($rose(avs_read || avs_write) |-> two_edge_answer)
		else $error("bus answer timing wrong");
endmodule
bind cmp_ctrl cmp_ctrl_chk i_cmp_ctrl_chk (.core_clk, .rst_n, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .chan_sel_low,
	.global_irq_en, .cmp_irq_req, .cmp_power_off_out, .cmp_bandgap_sel_out, .neg_use_mux,
	.neg_chan, .neg_chan_valid, .pin_change_block);

// >>> dv/cmp_ctrl_bench.sv
/*
 Self-checking bench for cmp_ctrl: registers, edge modes, flag clearing.
 Assumes the design and the checker are compiled first.
*/
`timescale 1ns/10ps
module cmp_ctrl_bench;
	reg         core_clk, rst_n, clk_en, avs_read, avs_write, cmp_out_async;
	reg         conv_enable, chan_sel_top, global_irq_en, vector_ack, f1, f2, g;
	reg  [1:0]  avs_address;
	reg  [31:0] avs_writedata, r;
	reg  [3:0]  avs_byteenable, chan_sel_low;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest, avs_response_err, cmp_irq_req, cmp_power_off_out;
	wire        cmp_bandgap_sel_out, neg_use_mux, neg_chan_valid, pin_change_block, irq;
	wire [3:0]  neg_chan;
	reg  [34:0] exp_q[$];
	integer     n_fail = 0, comparisons = 0, seed = 16803, m, i;

	cmp_ctrl i_cmp_ctrl (.core_clk, .rst_n, .clk_en, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err,
		.cmp_out_async, .conv_enable, .chan_sel_low, .chan_sel_top, .global_irq_en,
		.vector_ack, .cmp_irq_req, .cmp_power_off_out, .cmp_bandgap_sel_out, .neg_use_mux,
		.neg_chan, .neg_chan_valid, .pin_change_block, .irq);

	task stop_test;
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input [34:0] got, input [34:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	// Request held until waitrequest is seen low, then one idle edge
	task acc(input w, input [1:0] a, input [7:0] d, input [3:0] be);
		integer t;
		t = 0;
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		do begin
			@(posedge core_clk);
			t = t + 1;
		end while (avs_waitrequest !== 1'b0 && t < 40);
		if (avs_waitrequest !== 1'b0)
			n_fail++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input [1:0] a, input [2:0] ie, input [7:0] d);
		exp_q.push_back({ie, 24'h000000, d});
		acc(1'b0, a, 8'h00, 4'hF);
	endtask

	always @(posedge core_clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			check({irq, cmp_irq_req, avs_response_err, avs_readdata}, exp_q.pop_front());
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial begin
		{rst_n, avs_read, avs_write, cmp_out_async, conv_enable, chan_sel_top} = 6'h00;
		{vector_ack, avs_address, avs_writedata, chan_sel_low} = 39'h0;
		{clk_en, global_irq_en, avs_byteenable} = 6'h3F;
		tick(16);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd(2'h0, 3'h0, 8'h00);
		rd(2'h3, 3'h1, 8'h00);
		acc(1'b1, 2'h2, 8'h01, 4'h0);
		rd(2'h2, 3'h0, 8'h00);
		acc(1'b1, 2'h2, 8'h01, 4'hF);
		rd(2'h2, 3'h0, 8'h01);
		for (m = 0; m < 4; m++) begin
			g = (m != 2);
			f1 = (m == 0 || m == 3);
			f2 = (m == 0 || m == 2);
			global_irq_en <= g;
			// Enable off while the mode changes, so no stray request; bit 4 set clears the flag
			acc(1'b1, 2'h0, 8'h30 | m, 4'hF);
			acc(1'b1, 2'h1, 8'hFF, 4'hF);
			rd(2'h0, 3'h0, {6'h00, m[1:0]});
			acc(1'b1, 2'h0, 8'h08 | m, 4'hF);
			cmp_out_async <= 1'b1;
			tick(8);
			rd(2'h0, {f1, f1 & g, 1'b0}, {3'h1, f1, 2'h2, m[1:0]});
			vector_ack <= 1'b1;
			@(posedge core_clk);
			vector_ack <= 1'b0;
			cmp_out_async <= 1'b0;
			tick(8);
			rd(2'h0, {f1 | f2, f2 & g, 1'b0}, {3'h0, f2, 2'h2, m[1:0]});
			// Enable off before the next mode or power change
			acc(1'b1, 2'h0, 8'h00 | m, 4'hF);
		end
		acc(1'b1, 2'h0, 8'hC0, 4'hF);
		acc(1'b1, 2'h1, 8'hFF, 4'hF);
		cmp_out_async <= 1'b1;
		tick(8);
		rd(2'h0, 3'h0, 8'hE0);
		acc(1'b1, 2'h0, 8'h04, 4'hF);
		for (i = 0; i < 24; i++) begin
			r = $random(seed);
			{conv_enable, chan_sel_top, chan_sel_low} <= r[5:0];
			tick(3);
		end
		stop_test;
	end
endmodule
